// >>> rtl/fbws_defines.svh
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef FBWS_DEFINES_SVH
`define FBWS_DEFINES_SVH
`define FBWS_OFS_KEY 4'h0
`define FBWS_OFS_PSC 4'h1
`define FBWS_OFS_CACHE 4'h2
`define FBWS_OFS_STATUS 4'h3
`define FBWS_OFS_RDADDR 4'h4
`define FBWS_OFS_RDDATA 4'h5
`define FBWS_PSC_REDIRECT 0
`define FBWS_PSC_ERASE 1
`define FBWS_CACHE_BLOCK 0
`define FBWS_KEY1 8'hA5
`define FBWS_KEY2 8'hF1
`define FBWS_ERASED_BYTE 8'hFF
`define FBWS_PSC_RESET 8'h00
`define FBWS_CACHE_RESET 8'h00
`define FBWS_PROG_TIME_NS 2000
`define FBWS_CLK_PERIOD_NS 25
`endif

// >>> rtl/fbws_flash_mem.sv
// small flash array model with registered read port, bitwise programming
module fbws_flash_mem #(
	parameter int AW = 8
) (
	input wire logic clk_i, // system clock
	input wire logic we_i, // program strobe
	input wire logic [AW-1:0] waddr_i, // program address
	input wire logic [7:0] wdata_i, // program data
	input wire logic ee_i, // erase instead of program
	input wire logic [AW-1:0] raddr_i, // read address
	output logic [7:0] rdata_o // registered read data
);
	logic [7:0] mem [2**AW];
	// programming only clears bits; erase sets the byte to all ones
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= ee_i ? 8'hFF : (mem[waddr_i] & wdata_i);
		end
		rdata_o <= mem[raddr_i];
	end
endmodule : fbws_flash_mem

// >>> rtl/fbws_pkg.sv
// types shared by the flash block write sequencer
package fbws_pkg;
	typedef enum logic [1:0] {
		FBWS_KEY_IDLE = 2'b00,
		FBWS_KEY_HALF = 2'b01,
		FBWS_KEY_OPEN = 2'b11
	} fbws_key_type;
	typedef enum logic [1:0] {
		FBWS_PRG_IDLE = 2'b00,
		FBWS_PRG_BUSY = 2'b01,
		FBWS_PRG_LAST = 2'b11
	} fbws_prg_type;
endpackage : fbws_pkg

// >>> rtl/fbws_top.sv
// flash block write sequencer: key lock, redirect, block buffer, programming
//
// Operation
// - in block mode without erase programming waits until the last byte of a block.
// - a block is four bytes from low bits 00b to 11b in any code bank.
// - programming of the block starts right after the write to 11b.
// - while redirect is set, external-move writes go to flash.
// - the block select bit chosen before unlocking makes bytes buffer.
// - external-move reads always go to data RAM; flash only by code read.
`include "fbws_defines.svh"
module fbws_top import fbws_pkg::*; #(
	parameter int AW = 8
) (
	input wire logic clk_i, // system clock, 40 MHz
	input wire logic rst_n_i, // async reset, active low
	input wire logic [3:0] avs_address_i, // register word index
	input wire logic avs_read_i, // register read
	input wire logic avs_write_i, // register write
	input wire logic [31:0] avs_writedata_i, // register write data
	output logic [31:0] avs_readdata_o, // register read data
	output logic avs_waitrequest_o, // bus stall
	input wire logic xw_i, // external-move write strobe
	input wire logic xr_i, // external-move read strobe
	input wire logic [AW-1:0] xaddr_i, // external-move address
	input wire logic [7:0] xdata_i, // external-move write data
	output logic xram_we_o, // data RAM write strobe
	output logic xram_re_o, // data RAM read strobe
	output logic [AW-1:0] xram_addr_o, // data RAM address
	output logic [7:0] xram_wdata_o, // data RAM write data
	output logic busy_o // flash programming in progress
);
	// programming time rounded up to whole cycles; a slower clock only
	// stretches the busy window, it never cuts it below the cell time
	localparam int PROG_CYC = (`FBWS_PROG_TIME_NS + `FBWS_CLK_PERIOD_NS - 1)
		/ `FBWS_CLK_PERIOD_NS;
	localparam int CW = $clog2(PROG_CYC + 1);

	// lock and software-visible registers
	fbws_key_type key_reg, key_next;
	fbws_prg_type prg_reg, prg_next;
	logic [7:0] psc_reg, psc_next;
	logic [7:0] cache_reg, cache_next;
	logic [AW-1:0] rdaddr_reg, rdaddr_next;
	// block buffer and its bookkeeping
	logic [31:0] buf_reg, buf_next;
	logic [AW-1:0] base_reg, base_next;
	logic [3:0] valid_reg, valid_next;
	logic [1:0] idx_reg, idx_next;
	logic erase_reg, erase_next;
	// programming timer and error flag
	logic [CW-1:0] cnt_reg, cnt_next;
	logic err_reg, err_next;
	// bus answer and ram-side output stage
	logic [31:0] rd_reg, rd_next;
	logic wait_reg, wait_next;
	logic xwe_reg, xwe_next;
	logic xre_reg, xre_next;
	logic [AW-1:0] xaddr_reg, xaddr_next;
	logic [7:0] xwd_reg, xwd_next;
	logic busy_reg, busy_next;
	// flash array port
	logic fwe;
	logic [AW-1:0] fwaddr;
	logic [7:0] fwdata;
	logic [7:0] frdata;

	// byte lane select of the block buffer
	function automatic logic [7:0] lane(input logic [31:0] w,
		input logic [1:0] i);
		lane = w[8*i +: 8];
	endfunction : lane

	// flash array; programming one byte per cycle in the last four busy cycles
	// its read port is the code-read path, the only way to see flash
	fbws_flash_mem #(.AW(AW)) u_mem (
		.clk_i(clk_i),
		.we_i(fwe),
		.waddr_i(fwaddr),
		.wdata_i(fwdata),
		.ee_i(erase_reg),
		.raddr_i(rdaddr_reg),
		.rdata_o(frdata)
	);

	// program strobe: each valid buffered byte in the last busy cycles
	always_comb begin
		fwe = 1'b0;
		fwaddr = {base_reg[AW-1:2], idx_reg};
		fwdata = lane(buf_reg, idx_reg);
		if (prg_reg == FBWS_PRG_LAST && valid_reg[idx_reg]) begin
			fwe = 1'b1;
		end
	end

	// next state of the whole sequencer
	always_comb begin
		logic acc;
		logic rd;
		logic wr;
		logic fw;
		acc = 1'b0;
		rd = avs_read_i & wait_reg;
		// a write lands at the edge where the stall is seen low, as the
		// master sees it; a read is fetched one edge early so that its
		// data stand when the stall drops
		wr = avs_write_i & ~wait_reg;
		fw = 1'b0;
		key_next = key_reg;
		prg_next = prg_reg;
		psc_next = psc_reg;
		cache_next = cache_reg;
		rdaddr_next = rdaddr_reg;
		buf_next = buf_reg;
		base_next = base_reg;
		valid_next = valid_reg;
		idx_next = idx_reg;
		erase_next = erase_reg;
		cnt_next = cnt_reg;
		err_next = err_reg;
		rd_next = rd_reg;
		wait_next = 1'b1;
		xwe_next = 1'b0;
		xre_next = 1'b0;
		xaddr_next = xaddr_i;
		xwd_next = xdata_i;
		acc = avs_read_i | avs_write_i;
		// one wait cycle, then the access completes
		if (acc && wait_reg) begin
			wait_next = 1'b0;
		end
		// register reads; unmapped indices read zero
		// status is a snapshot taken at the request edge
		if (rd) begin
			unique case (avs_address_i)
			`FBWS_OFS_PSC: rd_next = {24'h000000, psc_reg};
			`FBWS_OFS_CACHE: rd_next = {24'h000000, cache_reg};
			`FBWS_OFS_STATUS: rd_next = {27'h0000000, err_reg,
				key_reg == FBWS_KEY_OPEN, prg_reg != FBWS_PRG_IDLE,
				valid_reg != 4'h0};
			`FBWS_OFS_RDADDR: rd_next = 32'(rdaddr_reg);
			`FBWS_OFS_RDDATA: rd_next = {24'h000000, frdata};
			default: rd_next = 32'h00000000;
			endcase
		end
		if (wr) begin
			unique case (avs_address_i)
			`FBWS_OFS_KEY: begin
				// wrong or extra key locks and flags an error
				// any other key write relocks, so a runaway loop can
				// never leave the array open by chance
				if (key_reg == FBWS_KEY_IDLE &&
					avs_writedata_i[7:0] == `FBWS_KEY1) begin
					key_next = FBWS_KEY_HALF;
				end else if (key_reg == FBWS_KEY_HALF &&
					avs_writedata_i[7:0] == `FBWS_KEY2) begin
					key_next = FBWS_KEY_OPEN;
				end else begin
					key_next = FBWS_KEY_IDLE;
					err_next = 1'b1;
				end
			end
			`FBWS_OFS_PSC: psc_next = {6'h00, avs_writedata_i[1:0]};
			`FBWS_OFS_CACHE: cache_next = {7'h00, avs_writedata_i[0]};
			`FBWS_OFS_STATUS: if (avs_writedata_i[3]) err_next = 1'b0;
			`FBWS_OFS_RDADDR: rdaddr_next = avs_writedata_i[AW-1:0];
			default: ;
			endcase
		end
		// external-move write: flash when redirected, else data RAM
		// a refused flash write is dropped whole: the core meant it for
		// flash, so the ram must not change behind its back either
		if (xw_i) begin
			if (psc_reg[`FBWS_PSC_REDIRECT]) begin
				if (key_reg == FBWS_KEY_OPEN &&
					prg_reg == FBWS_PRG_IDLE) begin
					fw = 1'b1;
					key_next = FBWS_KEY_IDLE;
				end else begin
					err_next = 1'b1;
				end
			end else begin
				xwe_next = 1'b1;
			end
		end
		// external-move reads never see flash
		xre_next = xr_i;
		// buffer bytes; program at the 11b byte, or at once in byte mode or with erase set
		// the buffer starts all ones so unwritten lanes leave cells alone
		if (fw) begin
			if (valid_reg == 4'h0) begin
				base_next = xaddr_i;
				buf_next = {4{`FBWS_ERASED_BYTE}};
			end
			if (valid_reg != 4'h0 &&
				xaddr_i[AW-1:2] != base_reg[AW-1:2]) begin
				err_next = 1'b1;
			end
			buf_next[8*xaddr_i[1:0] +: 8] = xdata_i;
			erase_next = psc_reg[`FBWS_PSC_ERASE];
			if (!cache_reg[`FBWS_CACHE_BLOCK] ||
				psc_reg[`FBWS_PSC_ERASE]) begin
				valid_next = 4'h0;
				valid_next[xaddr_i[1:0]] = 1'b1;
				base_next = xaddr_i;
				prg_next = FBWS_PRG_BUSY;
			end else begin
				valid_next = (valid_reg == 4'h0) ? 4'h0 : valid_reg;
				valid_next[xaddr_i[1:0]] = 1'b1;
				if (xaddr_i[1:0] == 2'b11) begin
					prg_next = FBWS_PRG_BUSY;
				end
			end
			cnt_next = CW'(PROG_CYC);
		end
		// programming timer; the cell writes happen at the end
		// one lane a cycle at the close of the window; a code read during
		// busy may still return the old contents
		unique case (prg_reg)
		FBWS_PRG_IDLE: ;
		FBWS_PRG_BUSY: begin
			if (cnt_reg <= CW'(1)) begin
				prg_next = FBWS_PRG_LAST;
				idx_next = 2'b00;
			end else begin
				cnt_next = cnt_reg - CW'(1);
			end
		end
		FBWS_PRG_LAST: begin
			idx_next = idx_reg + 2'b01;
			if (idx_reg == 2'b11) begin
				prg_next = FBWS_PRG_IDLE;
				valid_next = 4'h0;
			end
		end
		default: prg_next = FBWS_PRG_IDLE;
		endcase
		// busy follows the state in its own flop so the pin never glitches
		busy_next = (prg_next != FBWS_PRG_IDLE);
	end

	// register stage
	// the buffer resets to all ones, the value that leaves a cell unchanged
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			key_reg <= FBWS_KEY_IDLE;
			prg_reg <= FBWS_PRG_IDLE;
			psc_reg <= `FBWS_PSC_RESET;
			cache_reg <= `FBWS_CACHE_RESET;
			rdaddr_reg <= '0;
			buf_reg <= 32'hFFFFFFFF;
			base_reg <= '0;
			valid_reg <= 4'h0;
			idx_reg <= 2'b00;
			erase_reg <= 1'b0;
			cnt_reg <= '0;
			err_reg <= 1'b0;
			rd_reg <= 32'h00000000;
			wait_reg <= 1'b1;
			xwe_reg <= 1'b0;
			xre_reg <= 1'b0;
			xaddr_reg <= '0;
			xwd_reg <= 8'h00;
			busy_reg <= 1'b0;
		end else begin
			key_reg <= key_next;
			prg_reg <= prg_next;
			psc_reg <= psc_next;
			cache_reg <= cache_next;
			rdaddr_reg <= rdaddr_next;
			buf_reg <= buf_next;
			base_reg <= base_next;
			valid_reg <= valid_next;
			idx_reg <= idx_next;
			erase_reg <= erase_next;
			cnt_reg <= cnt_next;
			err_reg <= err_next;
			rd_reg <= rd_next;
			wait_reg <= wait_next;
			xwe_reg <= xwe_next;
			xre_reg <= xre_next;
			xaddr_reg <= xaddr_next;
			xwd_reg <= xwd_next;
			busy_reg <= busy_next;
		end
	end

	// outputs straight from flops
	// nothing is decoded on the way out, so no output can glitch
	assign avs_readdata_o = rd_reg;
	assign avs_waitrequest_o = wait_reg;
	assign xram_we_o = xwe_reg;
	assign xram_re_o = xre_reg;
	assign xram_addr_o = xaddr_reg;
	assign xram_wdata_o = xwd_reg;
	assign busy_o = busy_reg;
endmodule : fbws_top

// >>> testbench/fbws_core_model.sv
// core model issuing external-move writes and reads
module fbws_core_model (
	input wire logic clk_i, // system clock
	output logic xw_o, // write strobe
	output logic xr_o, // read strobe
	output logic [7:0] xaddr_o, // address
	output logic [7:0] xdata_o // write data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		xw_o = 1'b0;
		xr_o = 1'b0;
		xaddr_o = 8'h00;
		xdata_o = 8'h00;
	end
	// one-cycle strobe; released lines flip so stale values never match
	task mmove(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		xw_o <= w;
		xr_o <= !w;
		xaddr_o <= a;
		xdata_o <= d;
		@(posedge clk_i);
		xw_o <= 1'b0;
		xr_o <= 1'b0;
		xaddr_o <= ~a;
		xdata_o <= ~d;
	endtask : mmove
endmodule : fbws_core_model

// >>> testbench/fbws_top_properties.sv
// port checker of the flash block write sequencer
module fbws_top_checker #(
	parameter int AW = 8
) (
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic avs_read_i, // bus read
	input wire logic avs_write_i, // bus write
	input wire logic avs_waitrequest_o, // bus stall
	input wire logic xw_i, // ext write
	input wire logic xr_i, // ext read
	input wire logic [AW-1:0] xaddr_i, // ext address
	input wire logic [7:0] xdata_i, // ext data
	input wire logic xram_we_o, // ram write
	input wire logic xram_re_o, // ram read
	input wire logic [AW-1:0] xram_addr_o, // ram address
	input wire logic [7:0] xram_wdata_o, // ram data
	input wire logic busy_o // programming
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// reads stay on ram even with redirect set
	a_read_to_ram: assert property (
		xr_i |=> xram_re_o && xram_addr_o == $past(xaddr_i))
		else $error("ext read not sent to ram");
	a_ram_read_cause: assert property (
		xram_re_o |-> $past(xr_i)) else $error("stray ram read");
	// a ram write carries the byte of the write that caused it
	a_ram_write_cause: assert property (
		xram_we_o |-> $past(xw_i) && xram_wdata_o == $past(xdata_i))
		else $error("stray ram write");
	a_bus_answer: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=>
		!avs_waitrequest_o) else $error("bus answer late");
	a_bus_rearm: assert property (
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("stall not raised again");
	// programming only ever follows an external write
	a_busy_cause: assert property (
		$rose(busy_o) |-> $past(xw_i) || $past(xw_i, 2) || $past(xw_i, 3))
		else $error("busy without ext write");
	a_busy_hold: assert property (
		$rose(busy_o) |-> busy_o[*8]) else $error("busy dropped early");
	a_busy_end: assert property (
		$rose(busy_o) |-> ##[8:200] !busy_o) else $error("busy stuck");
endmodule : fbws_top_checker

bind fbws_top fbws_top_checker #(.AW(AW)) i_chk (.clk_i, .rst_n_i,
	.avs_read_i, .avs_write_i, .avs_waitrequest_o, .xw_i, .xr_i,
	.xaddr_i, .xdata_i, .xram_we_o, .xram_re_o, .xram_addr_o,
	.xram_wdata_o, .busy_o);

// >>> testbench/fbws_top_tb.sv
// self-checking bench of the flash block write sequencer
`include "fbws_defines.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
module fbws_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o, q;
	logic avs_waitrequest_o, xw_i, xr_i, xram_we_o, xram_re_o, busy_o;
	logic [7:0] xaddr_i, xdata_i, xram_addr_o, xram_wdata_o, d;
	logic [7:0] em[8];
	int error_cnt = 0;
	int checks_done = 0;
	int seed = 93439;
	always #12.5 clk_i = ~clk_i;
	fbws_top i_dut (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
		.xw_i, .xr_i, .xaddr_i, .xdata_i, .xram_we_o, .xram_re_o,
		.xram_addr_o, .xram_wdata_o, .busy_o);
	fbws_core_model i_core (.clk_i, .xw_o(xw_i), .xr_o(xr_i),
		.xaddr_o(xaddr_i), .xdata_o(xdata_i));
	// programming can only clear bits
	function automatic logic [7:0] prog(logic [7:0] o, logic [7:0] n);
		return o & n;
	endfunction : prog
	task report_and_stop;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// bus cycle held until stall is seen low; the watchdog ends a hang
	task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, v};
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask : bus
	task fw(input logic [7:0] a, input logic [7:0] v, input logic [7:0] p);
		bus(1, `FBWS_OFS_KEY, `FBWS_KEY1);
		bus(1, `FBWS_OFS_KEY, `FBWS_KEY2);
		bus(1, `FBWS_OFS_PSC, p);
		i_core.mmove(1, a, v);
		bus(1, `FBWS_OFS_PSC, 8'h00);
	endtask : fw
	// a stuck busy is left to the watchdog, which fails the run
	task idle;
		while (busy_o !== 1'b0) @(posedge clk_i);
	endtask : idle
	task fchk(input int i);
		bus(1, `FBWS_OFS_RDADDR, 8'h40 + 8'(i));
		repeat (2) @(posedge clk_i);
		bus(0, `FBWS_OFS_RDDATA, 8'h00);
		`CHK("flash", em[i], q[7:0])
	endtask : fchk
	initial begin
		#500000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		bus(0, 4'hF, 8'h00);
		`CHK("unmapped", 32'h0, q)
		// redirected read still lands on ram
		bus(1, `FBWS_OFS_PSC, 8'h01);
		i_core.mmove(0, 8'h55, 8'h00);
		@(negedge clk_i);
		`CHK("ram_re", 1'b1, xram_re_o)
		`CHK("ram_raddr", 8'h55, xram_addr_o)
		bus(1, `FBWS_OFS_PSC, 8'h00);
		d = 8'($random(seed));
		i_core.mmove(1, 8'h33, d);
		@(negedge clk_i);
		`CHK("ram_data", d, xram_wdata_o)
		`CHK("ram_we", 1'b1, xram_we_o)
		`CHK("ram_waddr", 8'h33, xram_addr_o)
		$display("test ram done");
		// erase then program byte by byte
		for (int i = 0; i < 8; i++) begin
			fw(8'h40 + 8'(i), 8'h00, 8'h03);
			idle();
			em[i] = 8'hFF;
		end
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			fw(8'h40 + 8'(i), d, 8'h01);
			idle();
			em[i] = prog(em[i], d);
		end
		// one unlock admits one byte: the second is refused
		bus(1, `FBWS_OFS_KEY, `FBWS_KEY1);
		bus(1, `FBWS_OFS_KEY, `FBWS_KEY2);
		bus(1, `FBWS_OFS_PSC, 8'h01);
		i_core.mmove(1, 8'h40, 8'hFF);
		@(posedge clk_i);
		idle();
		// lock closed again, no error, nothing pending
		bus(0, `FBWS_OFS_STATUS, 8'h00);
		`CHK("status", 4'h0, q[3:0])
		i_core.mmove(1, 8'h41, 8'h00);
		bus(1, `FBWS_OFS_PSC, 8'h00);
		idle();
		bus(0, `FBWS_OFS_STATUS, 8'h00);
		`CHK("err", 1'b1, q[3])
		bus(1, `FBWS_OFS_STATUS, 8'h08);
		bus(0, `FBWS_OFS_STATUS, 8'h00);
		`CHK("err_clear", 1'b0, q[3])
		$display("test byte done");
		// block mode, ascending, third byte left alone; the bench raises
		// no interrupt, so the sequence is never broken up
		bus(1, `FBWS_OFS_CACHE, 8'h01);
		for (int i = 4; i < 8; i++) begin
			d = (i == 6) ? 8'hFF : 8'($random(seed));
			fw(8'h40 + 8'(i), d, 8'h01);
			em[i] = prog(em[i], d);
			`CHK("busy", i == 7, busy_o)
			if (i < 7) begin
				bus(0, `FBWS_OFS_STATUS, 8'h00);
				`CHK("buffered", 1'b1, q[0])
			end
		end
		idle();
		bus(1, `FBWS_OFS_CACHE, 8'h00);
		for (int i = 0; i < 8; i++) fchk(i);
		$display("test block done");
		report_and_stop();
	end
endmodule : fbws_top_tb
